// [pkg/uart_tx_consts.vh]
// Constants for the serial transmit control block
// Assumes inclusion by bare name from design files
`ifndef UART_TX_CONSTS_VH
`define UART_TX_CONSTS_VH
`define OFF_MODE 8'h00
`define OFF_STATUS 8'h04
`define OFF_TXBUF 8'h08
`define OFF_BAUD 8'h0c
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14
`define BIT_POWER 7
`define BIT_TXEN 6
`define BIT_RXEN 5
`define BIT_PAR_HI 4
`define BIT_PAR_LO 3
`define BIT_BUF_FULL 1
`define BIT_SHIFTING 0
`define MODE_RESET 8'h00
`define BAUD_RESET 16'h0364
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [logic/tx_shifter.v]
// Frame shifter: start bit, 8 data bits LSB first, optional parity, stop bit
// Assumes baud_tick is a one-cycle enable from the parent divider
`include "uart_tx_consts.vh"
module tx_shifter (
  input wire sys_clk,
  input wire reset,
  input wire baud_tick,
  input wire load,
  input wire [7:0] data,
  input wire [1:0] parity_mode,
  input wire abort,
  output reg busy,
  output reg done,
  output reg txd
);
  reg [10:0] frame_reg;
  reg [3:0] left_reg;
  wire par_bit;
  assign par_bit = parity_mode[1] ? ~(^data) : (^data);
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      txd <= 1'b1;
      frame_reg <= 11'h7ff;
      left_reg <= 4'h0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        // Init during shift cuts the frame
        busy <= 1'b0;
        txd <= 1'b1;
        left_reg <= 4'h0;
      end else if (load) begin
        busy <= 1'b1;
        if (parity_mode == 2'b00) begin
          frame_reg <= {2'b11, data, 1'b0};
          left_reg <= 4'ha;
        end else begin
          frame_reg <= {1'b1, par_bit, data, 1'b0};
          left_reg <= 4'hb;
        end
      end else if (busy && baud_tick) begin
        txd <= frame_reg[0];
        frame_reg <= {1'b1, frame_reg[10:1]};
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h0) begin
          busy <= 1'b0;
          txd <= 1'b1;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // tx_shifter

// [logic/uart_tx_ctrl.v]
// Serial transmit control: mode register, transmit buffer, status flags, interrupt
// Assumes an AXI4-Lite master on the same clock; txd goes to the remote node
// Behaviour
// R01 - Stop: clear enables, then clear power
// R02 - Start: set power, then set enables
// R03 - LIN use keeps parity select at zero
// R04 - Flags run 10, 11, 01 when streaming
// R05 - Software judges queueing by buffer-full only
// R06 - LIN: wait for status zero per byte
// R07 - Next byte only after buffer-full reads 0
// R08 - Write while full corrupts the pending byte
// R09 - Reinit only after interrupt and shifting 0
// R10 - Reinit during shift may corrupt frame
// R11 - Completion interrupt after every sent frame
// R12 - Software counts bytes to catch missed completions
// R13 - Full set on write, cleared on move
`include "uart_tx_consts.vh"
module uart_tx_ctrl #(
  parameter [15:0] BAUD_DIV_RESET = `BAUD_RESET
) (
  input wire sys_clk,
  input wire reset,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire txd,
  output wire irq
);
  reg [7:0] mode_reg;
  reg [7:0] buf_reg;
  reg buf_full_reg;
  reg [15:0] baud_div_reg;
  reg [15:0] baud_cnt_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;
  reg [7:0] aw_addr_reg;
  reg aw_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_held_reg;
  wire baud_tick;
  wire shifting;
  wire frame_done;
  wire tx_active;
  wire load;
  wire do_write;
  wire do_read;
  wire wr_mode;
  wire wr_buf;
  wire rd_irq;
  wire [7:0] status_val;
  reg [31:0] rd_val;
  reg rd_ok;
  reg wr_ok;
  reg tx_active_reg;
  wire wr_baud;
  wire wr_mask;
  wire drop_pending;
  wire shift_abort;
  wire [1:0] parity_mode;
  wire [1:0] irq_events;
  // Transmitter runs only with power and transmit enable both set
  assign tx_active = mode_reg[`BIT_POWER] & mode_reg[`BIT_TXEN]; // [R01] [R02]
  // Status byte: buffer full above shifting
  assign status_val = {6'h00, buf_full_reg, shifting};
  // Write channel: address and data captured in either order
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read = s_axi_arvalid & ~s_axi_rvalid;
  assign wr_mode = do_write & (aw_addr_reg == `OFF_MODE) & w_strb_reg[0];
  assign wr_buf = do_write & (aw_addr_reg == `OFF_TXBUF) & w_strb_reg[0];
  assign rd_irq = do_read & (s_axi_araddr == `OFF_IRQ_STATUS);
  assign wr_baud = do_write & (aw_addr_reg == `OFF_BAUD);
  assign wr_mask = do_write & (aw_addr_reg == `OFF_IRQ_MASK);
  // Enable just dropped: pending byte discarded
  assign drop_pending = tx_active_reg & ~tx_active; // [R10]
  assign shift_abort = ~tx_active; // [R10]
  // Parity select pair as the shifter sees it
  assign parity_mode = {mode_reg[`BIT_PAR_HI], mode_reg[`BIT_PAR_LO]}; // [R03]
  // Bit 1 byte moved to shifter, bit 0 frame done
  assign irq_events = {load, frame_done}; // [R11]
  // Buffered byte moves to the shifter once it is idle, power and transmit enable are both set and no buffer write falls in that cycle
  assign load = buf_full_reg & ~shifting & tx_active & ~wr_buf; // [R13]
  assign baud_tick = (baud_cnt_reg == 16'h0000);
  // Level interrupt from masked sticky status
  assign irq = |(irq_status_reg & irq_mask_reg);
  always @* begin
    wr_ok = 1'b1;
    case (aw_addr_reg)
      `OFF_MODE, `OFF_TXBUF, `OFF_BAUD, `OFF_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end
  // Read mux; unmapped offsets answer zero with an error
  always @* begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFF_MODE: rd_val = {24'h000000, mode_reg};
      `OFF_STATUS: rd_val = {24'h000000, status_val}; // [R04]
      `OFF_TXBUF: rd_val = {24'h000000, buf_reg};
      `OFF_BAUD: rd_val = {16'h0000, baud_div_reg};
      `OFF_IRQ_STATUS: rd_val = {30'h00000000, irq_status_reg};
      `OFF_IRQ_MASK: rd_val = {30'h00000000, irq_mask_reg};
      default: rd_ok = 1'b0;
    endcase
  end
  tx_shifter shifter (
    .sys_clk(sys_clk),
    .reset(reset),
    .baud_tick(baud_tick),
    .load(load),
    .data(buf_reg),
    .parity_mode(parity_mode),
    .abort(shift_abort),
    .busy(shifting),
    .done(frame_done),
    .txd(txd)
  );
  // Bus handshakes and responses
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_addr_reg <= 8'h00;
      aw_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      w_held_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= `MODE_RESET;
      buf_reg <= 8'h00;
      buf_full_reg <= 1'b0;
      baud_div_reg <= BAUD_DIV_RESET;
      baud_cnt_reg <= 16'h0000;
      irq_status_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
    end else begin
      // Divider reloads on each tick and while stopped
      if (~tx_active || baud_tick) begin
        baud_cnt_reg <= baud_div_reg;
      end else begin
        baud_cnt_reg <= baud_cnt_reg - 16'h0001;
      end
      if (wr_mode) begin
        mode_reg <= w_data_reg[7:0];
      end
      if (wr_baud) begin
        baud_div_reg <= w_data_reg[15:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= w_data_reg[1:0];
      end
      // Buffer write: overwrites a pending byte when already full
      if (wr_buf) begin
        buf_reg <= w_data_reg[7:0]; // [R08]
        buf_full_reg <= 1'b1; // [R13] [R04]
      end else if (load) begin
        buf_full_reg <= 1'b0; // [R13] [R04]
      end else if (drop_pending) begin
        buf_full_reg <= 1'b0; // [R10]
      end
      // Set wins over read clear
      irq_status_reg <= (rd_irq ? 2'b00 : irq_status_reg) | irq_events; // [R11]
    end
  end
  // Enable state one cycle back, for the drop pulse
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_active_reg <= 1'b0;
    end else begin
      tx_active_reg <= tx_active;
    end
  end
endmodule // uart_tx_ctrl

// [verif/uart_tx_ctrl_asserts.sv]
// Port checker for uart_tx_ctrl
// Assumes bind onto the design top
module uart_tx_ctrl_checker (
  input wire sys_clk,
  input wire reset,
  input wire txd,
  input wire irq,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_start_bit_held: assert property ($fell(txd) |-> !txd [*2])
    else $error("start bit short");
  a_irq_at_stop: assert property ($rose(irq) |-> txd)
    else $error("irq rose mid frame");
  a_write_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken with response pending");
  a_read_one_only: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken with data pending");
  a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
    else $error("refused read not zero");
  c_irq: cover property ($rose(irq));
  c_frame: cover property ($fell(txd));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // uart_tx_ctrl_checker
bind uart_tx_ctrl uart_tx_ctrl_checker u_chk (.sys_clk, .reset, .txd, .irq, .s_axi_awready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata);

// [verif/serial_receiver.sv]
// Remote node: takes 8-bit frames off txd, parity bit optional
// Assumes a bit period of BIT clocks
module serial_receiver #(
  parameter int BIT = 4
) (
  input wire logic sys_clk,
  input wire logic txd,
  input wire logic par_en,
  output logic par_bit,
  output logic [7:0] rx_byte,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  int nbits;
  initial begin
    rx_byte = 0;
    par_bit = 0;
    frames = 0;
    forever begin
      @(negedge txd);
      // Frame length fixed at the start bit
      nbits = par_en ? 10 : 9;
      repeat (BIT / 2) @(negedge sys_clk);
      for (int i = 0; i < nbits; i++) begin
        repeat (BIT) @(negedge sys_clk);
        if (i < 8) sh[i] = txd;
        if (i == 8 && nbits == 10) par_bit = txd;
      end
      if (txd) rx_byte = sh;
      if (txd) frames++;
    end
  end
endmodule // serial_receiver

// [verif/uart_tx_ctrl_tb.sv]
// Bench for uart_tx_ctrl over AXI4-Lite
// Assumes the receiver model on txd
module uart_tx_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int mismatches, n_compared, frames;
  logic par_en, par_bit;
  uart_tx_ctrl #(.BAUD_DIV_RESET(16'h0003)) u_dut (.sys_clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd, .irq);
  serial_receiver #(.BIT(4)) u_rx (.sys_clk, .txd, .par_en, .par_bit, .rx_byte, .frames);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One AXI transfer, waits for its response
  task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, fin;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    fin = 0;
    while (!fin) begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      fin = w ? s_axi_bvalid : s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
      if (fin) {s_axi_bready, s_axi_rready} <= 2'b00;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    axi(0, a, 0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic wait_irq;
    for (int n = 0; n < 300 && irq !== 1'b1; n++) @(negedge sys_clk);
    chk("irq", 1, irq);
  endtask
  task automatic poll(input logic [31:0] m);
    rd = m;
    while ((rd & m) != 0) axi(0, 8'h04, 0);
  endtask
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
  initial begin
    reset = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    par_en = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h0c, 32'h3);
    axi(0, 8'h18, 0);
    chk("resp", 32'h2, {30'h0, rsp});
    axi(1, 8'h18, 32'h1);
    chk("wresp", 32'h2, {30'h0, rsp});
    axi(1, 8'h14, 32'h1);
    axi(1, 8'h00, 32'h80);
    axi(1, 8'h00, 32'hc0);
    axi(1, 8'h08, 32'h5a);
    rdc(8'h04, 32'h1);
    axi(1, 8'h08, 32'ha5);
    rdc(8'h04, 32'h3);
    poll(32'h2);
    chk("status", 32'h1, rd);
    wait_irq;
    chk("byte", 32'h5a, rx_byte);
    rdc(8'h10, 32'h3);
    chk("irq", 0, irq);
    wait_irq;
    poll(32'h1);
    chk("frames", 2, frames);
    chk("byte", 32'ha5, rx_byte);
    rdc(8'h10, 32'h1);
    axi(1, 8'h00, 32'h80);
    poll(32'h3);
    chk("status", 32'h0, rd);
    axi(1, 8'h08, 32'h11);
    axi(1, 8'h08, 32'h22);
    rdc(8'h04, 32'h2);
    axi(1, 8'h00, 32'hc0);
    wait_irq;
    chk("byte", 32'h22, rx_byte);
    axi(1, 8'h08, 32'h33);
    repeat (20) @(posedge sys_clk);
    axi(1, 8'h00, 32'h80);
    axi(1, 8'h00, 32'h00);
    rdc(8'h04, 32'h0);
    rdc(8'h10, 32'h3);
    par_en <= 1'b1;
    axi(1, 8'h00, 32'h80);
    axi(1, 8'h00, 32'hd0);
    axi(1, 8'h08, 32'h07);
    wait_irq;
    chk("byte", 32'h07, rx_byte);
    chk("parity", 32'h0, par_bit);
    rdc(8'h10, 32'h3);
    axi(1, 8'h00, 32'hc8);
    axi(1, 8'h08, 32'h0b);
    wait_irq;
    chk("byte", 32'h0b, rx_byte);
    chk("parity", 32'h1, par_bit);
    give_verdict;
  end
endmodule // uart_tx_ctrl_tb
